// [common/aau_pkg.sv]
// How it works
// RL1: Add immediate to accumulator, result in accumulator.
// RL2: Add memory byte and accumulator, chosen destination.
// RL3: Add memory, accumulator and carry, chosen destination.
// RL4: Add carry flag into the accumulator.
// RL5: Add carry flag into a memory byte.
// RL6: Accumulator destination: memory minus accumulator.
// RL7: Memory destination: accumulator minus memory byte.
// RL8: Accumulator minus immediate, into the accumulator.
// RL9: Accumulator minus memory, into the accumulator.
// RL10: Memory minus accumulator, back into memory.
// RL11: Accumulator minus memory minus carry, into accumulator.
// RL12: Memory minus accumulator minus carry, into memory.
// RL13: Subtract carry flag from the accumulator.
// RL14: Subtract carry flag from a memory byte.
// RL15: Increment writes memory byte plus one back.
// RL16: Decrement writes memory byte minus one back.
// RL17: Clear writes zero into the memory byte.
// RL18: Arithmetic operations update all four flags.
// RL19: Eight-bit data; zero, carry/borrow, nibble carry flags.
// RL20: Overflow flag marks signed result out of range.
package aau_pkg;

   localparam int AAU_DW = 8;
   localparam int AAU_MAW = 8;
   localparam int AAU_RAW = 2;

   // Register port offsets.
   localparam logic [1:0] AAU_OFS_ACC = 2'h0;
   localparam logic [1:0] AAU_OFS_FLAGS = 2'h1;
   localparam logic [1:0] AAU_OFS_STATUS = 2'h2;

   // Flag register field positions.
   localparam int AAU_FLG_Z = 0;
   localparam int AAU_FLG_C = 1;
   localparam int AAU_FLG_AC = 2;
   localparam int AAU_FLG_OV = 3;

   // Reset values.
   localparam logic [7:0] AAU_ACC_RST = 8'h00;
   localparam logic [3:0] AAU_FLAGS_RST = 4'h0;

   typedef enum logic [3:0] {
      AAU_OP_ADD_I = 4'h0,
      AAU_OP_ADD = 4'h1,
      AAU_OP_ADDC = 4'h2,
      AAU_OP_ADDC1 = 4'h3,
      AAU_OP_NADD = 4'h4,
      AAU_OP_SUB_I = 4'h5,
      AAU_OP_SUB = 4'h6,
      AAU_OP_SUBC = 4'h7,
      AAU_OP_SUBC1 = 4'h8,
      AAU_OP_INC = 4'h9,
      AAU_OP_DEC = 4'ha,
      AAU_OP_CLR = 4'hb
   } aau_op_e;

   typedef enum logic [3:0] {
      AAU_ST_IDLE = 4'b0001,
      AAU_ST_READ = 4'b0010,
      AAU_ST_WAIT = 4'b0100,
      AAU_ST_EXEC = 4'b1000
   } aau_state_e;

endpackage

// [src/aau_adder.sv]
`timescale 1ns/1ps
module aau_adder
   import aau_pkg::*;
(
   // Operands.
   input wire logic [7:0] x,
   input wire logic [7:0] y,
   input wire logic sub,
   input wire logic cin,
   // Result and flags.
   output logic [7:0] sum,
   output logic carry,
   output logic aux,
   output logic ovf,
   output logic zero
);

   logic [7:0] yy;
   logic ci;
   logic [8:0] full;
   logic [4:0] low;

   // Subtraction adds the inverted operand and turns borrow into carry.
   always_comb
   begin
      yy = sub ? ~y : y;
      ci = sub ? ~cin : cin;
      full = {1'b0, x} + {1'b0, yy} + {8'h00, ci};
      low = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci};
      sum = full[7:0];
      carry = sub ? ~full[8] : full[8]; // RL19
      aux = sub ? ~low[4] : low[4]; // RL19
      ovf = (x[7] == yy[7]) && (full[7] != x[7]); // RL20
      zero = (full[7:0] == 8'h00); // RL19
   end

endmodule // aau_adder

// [src/aau_core.sv]
`timescale 1ns/1ps
module aau_core
   import aau_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Operation request from the decoder.
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic op_dst_mem,
   input wire logic [AAU_MAW-1:0] op_addr,
   input wire logic [AAU_DW-1:0] op_imm,
   output logic op_busy,
   output logic op_done,
   // Data memory.
   output logic mem_re,
   output logic mem_we,
   output logic [AAU_MAW-1:0] mem_addr,
   output logic [AAU_DW-1:0] mem_wdata,
   input wire logic [AAU_DW-1:0] mem_rdata,
   // Register port.
   input wire logic [AAU_RAW-1:0] reg_addr,
   input wire logic [AAU_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [AAU_DW-1:0] reg_rdata,
   // Architectural state.
   output logic [AAU_DW-1:0] accumulator,
   output logic zero_flag,
   output logic carry_flag,
   output logic aux_carry_flag,
   output logic overflow_flag
);

   typedef struct packed {
      aau_state_e st;
      aau_op_e op;
      logic dst_mem;
      logic [AAU_MAW-1:0] addr;
      logic [AAU_DW-1:0] opnd;
      logic [AAU_DW-1:0] acc;
      logic [3:0] flags;
      logic busy;
      logic done;
      logic mem_re;
      logic mem_we;
      logic [AAU_DW-1:0] wdata;
      logic [AAU_DW-1:0] rdata;
   } aau_reg_s;

   aau_reg_s q;
   aau_reg_s d;

   logic [7:0] ax;
   logic [7:0] ay;
   logic asub;
   logic acin;
   logic to_mem;
   logic [7:0] res;
   logic res_c;
   logic res_ac;
   logic res_ov;
   logic res_z;
   logic cflag;

   assign cflag = q.flags[AAU_FLG_C];

   // Decides whether an operation needs the memory byte read first.
   function automatic logic needs_read(input aau_op_e op, input logic dst);
      logic r;
      r = 1'b1;
      case (op)
         AAU_OP_ADD_I: r = 1'b0;
         AAU_OP_SUB_I: r = 1'b0;
         AAU_OP_CLR: r = 1'b0;
         AAU_OP_ADDC1: r = dst;
         AAU_OP_SUBC1: r = dst;
         default: r = 1'b1;
      endcase
      return r;
   endfunction

   // Picks adder operands and the result destination for the held operation.
   always_comb
   begin
      ax = q.acc;
      ay = q.opnd;
      asub = 1'b0;
      acin = 1'b0;
      to_mem = q.dst_mem;
      case (q.op)
         AAU_OP_ADD_I:
         begin
            to_mem = 1'b0; // RL1
         end
         AAU_OP_ADD:
         begin
            acin = 1'b0; // RL2
         end
         AAU_OP_ADDC:
         begin
            acin = cflag; // RL3
         end
         AAU_OP_ADDC1:
         begin
            ax = q.dst_mem ? q.opnd : q.acc; // RL4 RL5
            ay = 8'h00;
            acin = cflag;
         end
         AAU_OP_NADD:
         begin
            ax = q.dst_mem ? q.acc : q.opnd; // RL6 RL7
            ay = q.dst_mem ? q.opnd : q.acc;
            asub = 1'b1;
         end
         AAU_OP_SUB_I:
         begin
            asub = 1'b1; // RL8
            to_mem = 1'b0;
         end
         AAU_OP_SUB:
         begin
            ax = q.dst_mem ? q.opnd : q.acc; // RL9 RL10
            ay = q.dst_mem ? q.acc : q.opnd;
            asub = 1'b1;
         end
         AAU_OP_SUBC:
         begin
            ax = q.dst_mem ? q.opnd : q.acc; // RL11 RL12
            ay = q.dst_mem ? q.acc : q.opnd;
            asub = 1'b1;
            acin = cflag;
         end
         AAU_OP_SUBC1:
         begin
            ax = q.dst_mem ? q.opnd : q.acc; // RL13 RL14
            ay = 8'h00;
            asub = 1'b1;
            acin = cflag;
         end
         AAU_OP_INC:
         begin
            ax = q.opnd; // RL15
            ay = 8'h00;
            acin = 1'b1;
            to_mem = 1'b1;
         end
         AAU_OP_DEC:
         begin
            ax = q.opnd; // RL16
            ay = 8'h00;
            asub = 1'b1;
            acin = 1'b1;
            to_mem = 1'b1;
         end
         AAU_OP_CLR:
         begin
            to_mem = 1'b1; // RL17
         end
         default:
         begin
            to_mem = 1'b0;
         end
      endcase
   end

   aau_adder u_adder (
      .x(ax),
      .y(ay),
      .sub(asub),
      .cin(acin),
      .sum(res),
      .carry(res_c),
      .aux(res_ac),
      .ovf(res_ov),
      .zero(res_z)
   );

   // Sequencer, result write-back and register port.
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      d.mem_re = 1'b0;
      d.mem_we = 1'b0;
      d.rdata = 8'h00;
      case (q.st)
         AAU_ST_IDLE:
         begin
            if (op_valid)
            begin
               d.op = aau_op_e'(op_code);
               d.dst_mem = op_dst_mem;
               d.addr = op_addr;
               d.opnd = op_imm;
               if (needs_read(aau_op_e'(op_code), op_dst_mem))
               begin
                  d.st = AAU_ST_READ;
                  d.mem_re = 1'b1;
               end
               else
               begin
                  d.st = AAU_ST_EXEC;
               end
            end
         end
         AAU_ST_READ:
         begin
            d.st = AAU_ST_WAIT;
         end
         AAU_ST_WAIT:
         begin
            d.opnd = mem_rdata;
            d.st = AAU_ST_EXEC;
         end
         AAU_ST_EXEC:
         begin
            d.st = AAU_ST_IDLE;
            d.done = 1'b1;
            if (q.op == AAU_OP_CLR)
            begin
               d.mem_we = 1'b1; // RL17
               d.wdata = 8'h00;
            end
            else
            begin
               d.flags[AAU_FLG_Z] = res_z; // RL18 RL19
               d.flags[AAU_FLG_C] = res_c; // RL18 RL19
               d.flags[AAU_FLG_AC] = res_ac; // RL18 RL19
               d.flags[AAU_FLG_OV] = res_ov; // RL18 RL20
               if (to_mem)
               begin
                  d.mem_we = 1'b1;
                  d.wdata = res;
               end
               else
               begin
                  d.acc = res;
               end
            end
         end
         default:
         begin
            d.st = AAU_ST_IDLE;
         end
      endcase
      if (reg_wr && (reg_addr == AAU_OFS_ACC))
      begin
         d.acc = reg_wdata;
      end
      if (reg_wr && (reg_addr == AAU_OFS_FLAGS))
      begin
         d.flags = reg_wdata[3:0];
      end
      if (reg_rd)
      begin
         case (reg_addr)
            AAU_OFS_ACC: d.rdata = q.acc;
            AAU_OFS_FLAGS: d.rdata = {4'h0, q.flags};
            AAU_OFS_STATUS: d.rdata = {q.op, q.st};
            default: d.rdata = 8'h00;
         endcase
      end
      d.busy = (d.st != AAU_ST_IDLE);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '{st: AAU_ST_IDLE, op: AAU_OP_ADD_I, dst_mem: 1'b0, addr: '0, opnd: 8'h00,
                acc: AAU_ACC_RST, flags: AAU_FLAGS_RST, busy: 1'b0, done: 1'b0,
                mem_re: 1'b0, mem_we: 1'b0, wdata: 8'h00, rdata: 8'h00};
      end
      else
      begin
         q <= d;
      end
   end

   assign op_busy = q.busy;
   assign op_done = q.done;
   assign mem_re = q.mem_re;
   assign mem_we = q.mem_we;
   assign mem_addr = q.addr;
   assign mem_wdata = q.wdata;
   assign reg_rdata = q.rdata;
   assign accumulator = q.acc;
   assign zero_flag = q.flags[AAU_FLG_Z];
   assign carry_flag = q.flags[AAU_FLG_C];
   assign aux_carry_flag = q.flags[AAU_FLG_AC];
   assign overflow_flag = q.flags[AAU_FLG_OV];

   // Checks on the memory operand read sequence and the datapath results.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   logic ex;
   logic no_bus_wr;
   assign ex = (q.st == AAU_ST_EXEC);
   assign no_bus_wr = !reg_wr;

   sequence take_mem_op;
      (q.st == AAU_ST_IDLE) && op_valid && needs_read(aau_op_e'(op_code), op_dst_mem);
   endsequence

   sequence read_then_exec;
      mem_re ##1 !mem_re ##1 ex ##1 op_done;
   endsequence

   mem_read_order_a: assert property (take_mem_op |=> read_then_exec) // RL2
      else $error("memory operand sequence broken");

   add_imm_acc_a: assert property (ex && q.op == AAU_OP_ADD_I && no_bus_wr // RL1
      |=> accumulator == 8'($past(q.acc) + $past(q.opnd)))
      else $error("add immediate result wrong");

   sub_imm_acc_a: assert property (ex && q.op == AAU_OP_SUB_I && no_bus_wr // RL8
      |=> accumulator == 8'($past(q.acc) - $past(q.opnd)))
      else $error("subtract immediate result wrong");

   inc_mem_a: assert property (ex && q.op == AAU_OP_INC // RL15
      |=> mem_we && mem_wdata == 8'($past(q.opnd) + 8'h01))
      else $error("increment result wrong");

   dec_mem_a: assert property (ex && q.op == AAU_OP_DEC // RL16
      |=> mem_we && mem_wdata == 8'($past(q.opnd) - 8'h01))
      else $error("decrement result wrong");

   clear_mem_a: assert property (ex && q.op == AAU_OP_CLR && no_bus_wr // RL17
      |=> mem_we && mem_wdata == 8'h00 && $stable(q.flags))
      else $error("clear result wrong");

   subc_acc_a: assert property (ex && q.op == AAU_OP_SUBC && !q.dst_mem && no_bus_wr // RL11
      |=> accumulator == 8'($past(q.acc) - $past(q.opnd) - {7'h00, $past(cflag)}))
      else $error("subtract with borrow result wrong");

   zero_flag_a: assert property (ex && q.op != AAU_OP_CLR && no_bus_wr // RL19
      |=> zero_flag == ($past(res) == 8'h00))
      else $error("zero flag wrong");

   borrow_flag_a: assert property (ex && q.op == AAU_OP_SUB && no_bus_wr // RL19
      |=> carry_flag == ($past(ax) < $past(ay)))
      else $error("borrow flag wrong");

   overflow_flag_a: assert property (ex && q.op == AAU_OP_ADD && no_bus_wr // RL20
      |=> overflow_flag == (($past(ax[7]) == $past(ay[7]))
                            && ($past(res[7]) != $past(ax[7]))))
      else $error("overflow flag wrong");

endmodule // aau_core

// [dv/aau_mem_model.sv]
`timescale 1ns/1ps
module aau_mem_model
   import aau_pkg::*;
(
   // Clock.
   input wire logic clk_sys,
   // Memory port.
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [AAU_MAW-1:0] mem_addr,
   input wire logic [AAU_DW-1:0] mem_wdata,
   output logic [AAU_DW-1:0] mem_rdata
);
   logic [AAU_DW-1:0] mem [256];
   logic [AAU_DW-1:0] rdata_q = 8'h00;

   // Read data stand one cycle, then the bus toggles so stale data never pass.
   always @(posedge clk_sys)
   begin
      if (mem_we)
      begin
         mem[mem_addr] <= mem_wdata;
      end
      rdata_q <= mem_re ? mem[mem_addr] : ~rdata_q;
   end

   assign mem_rdata = rdata_q;
endmodule // aau_mem_model

// [dv/tb_accumulator_arith_unit.sv]
`timescale 1ns/1ps
module tb_accumulator_arith_unit
   import aau_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0, op_dst_mem = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] op_code = 4'h0;
   logic [7:0] op_addr = 8'h00, op_imm = 8'h00, reg_wdata = 8'h00;
   logic [1:0] reg_addr = 2'h0;
   logic op_busy, op_done, mem_re, mem_we;
   logic zero_flag, carry_flag, aux_carry_flag, overflow_flag;
   logic [7:0] mem_addr, mem_wdata, mem_rdata, reg_rdata, accumulator;
   logic [15:0] lf = 16'hd161;
   int mismatches = 0, checks = 0;
   logic [7:0] bnd [4] = '{8'h00, 8'hff, 8'h7f, 8'h80};

   aau_core DUT (.clk_sys, .rst_n, .op_valid, .op_code, .op_dst_mem, .op_addr, .op_imm,
      .op_busy, .op_done, .mem_re, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .accumulator,
      .zero_flag, .carry_flag, .aux_carry_flag, .overflow_flag);

   aau_mem_model u_mem (.clk_sys, .mem_re, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);

   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [7:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction

   // Returns {overflow, nibble carry, carry or borrow, zero, result}.
   function automatic logic [11:0] alu(int x, int y, int s, int ci);
      int r, h, c, v;
      r = s ? x - y - ci : x + y + ci;
      h = s ? (x % 16) - (y % 16) - ci < 0 : (x % 16) + (y % 16) + ci > 15;
      c = s ? r < 0 : r > 255;
      v = s ? (x ^ y) & (x ^ r) : ~(x ^ y) & (x ^ r);
      r = r & 255;
      return {v[7], h[0], c[0], r == 0, r[7:0]};
   endfunction

   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(logic [1:0] a, logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // A clear is poked at the design while it is busy; it must be ignored.
   task automatic op(int c, int d, logic [7:0] a, logic [7:0] m, logic [7:0] im);
      int x, y, s, ci, wm, n, lat;
      logic [7:0] f, ad, ea, em;
      logic [11:0] r;
      f = rnd() & 8'h0f;
      ad = rnd();
      wr(AAU_OFS_ACC, a);
      wr(AAU_OFS_FLAGS, f);
      u_mem.mem[ad] = m;
      u_mem.mem[ad ^ 8'h01] = ~m;
      s = 0;
      ci = 0;
      wm = d;
      x = a;
      y = m;
      case (c)
         0: begin y = im; wm = 0; end
         1: ;
         2: ci = f[1];
         3: begin x = d ? m : a; y = 0; ci = f[1]; end
         4: begin s = 1; x = d ? a : m; y = d ? m : a; end
         5: begin s = 1; y = im; wm = 0; end
         6: begin s = 1; x = d ? m : a; y = d ? a : m; end
         7: begin s = 1; x = d ? m : a; y = d ? a : m; ci = f[1]; end
         8: begin s = 1; x = d ? m : a; y = 0; ci = f[1]; end
         9: begin y = 1; x = m; wm = 1; end
         10: begin s = 1; x = m; y = 1; wm = 1; end
         default: wm = 1;
      endcase
      r = (c == 11) ? {f[3:0], 8'h00} : alu(x, y, s, ci);
      ea = wm ? a : r[7:0];
      em = wm ? r[7:0] : m;
      lat = (c == 0 || c == 5 || c == 11 || ((c == 3 || c == 8) && !d)) ? 2 : 4;
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_code <= c[3:0];
      op_dst_mem <= d[0];
      op_addr <= ad;
      op_imm <= im;
      @(posedge clk_sys);
      op_code <= AAU_OP_CLR;
      op_addr <= ad ^ 8'h01;
      #1;
      chk("busy_take", 8'h01, {7'h00, op_busy});
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1;
      n = 2;
      while (op_done !== 1'b1)
      begin
         @(posedge clk_sys);
         n++;
         #1;
         if (n > 12)
         begin
            mismatches++;
            conclude();
         end
      end
      chk("latency", lat[7:0], n[7:0]);
      chk("busy_done", 8'h00, {7'h00, op_busy});
      chk("acc", ea, accumulator);
      chk("flags", {4'h0, r[11:8]}, {4'h0, overflow_flag, aux_carry_flag, carry_flag,
         zero_flag});
      @(posedge clk_sys);
      #1;
      chk("mem", em, u_mem.mem[ad]);
      chk("mem_busy", ~m, u_mem.mem[ad ^ 8'h01]);
   endtask

   initial
   begin
      logic [7:0] v;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(AAU_OFS_ACC, v);
      chk("acc_rst", AAU_ACC_RST, v);
      rd(AAU_OFS_FLAGS, v);
      chk("flags_rst", {4'h0, AAU_FLAGS_RST}, v);
      wr(2'h3, 8'h5a);
      rd(2'h3, v);
      chk("unmapped", 8'h00, v);
      wr(AAU_OFS_FLAGS, 8'h0a);
      rd(AAU_OFS_FLAGS, v);
      chk("flags_rw", 8'h0a, v & 8'h0f);
      rd(AAU_OFS_STATUS, v);
      chk("status", 8'h01, v & 8'h0f);
      $display("test registers done");
      for (int k = 0; k < 8; k++)
         for (int c = 0; c < 12; c++)
            for (int d = 0; d < 2; d++)
               op(c, d, k < 4 ? bnd[k] : rnd(), k < 4 ? bnd[3 - k] : rnd(),
                  k < 4 ? 8'h01 : rnd());
      $display("test operations done");
      conclude();
   end
endmodule // tb_accumulator_arith_unit
